// File: bench/dch_port_monitor.sv
// Purpose: checks on the byte bus between host bridge and controller
// Assumes: one clock, sync reset active high
// Notes: status shows on rdata the cycle after a status select
`timescale 1ns/1ps
`default_nettype none
module dch_port_monitor (
   input wire logic core_clk_in, // clock
   input wire logic rst_in, // reset
   input wire logic register_select_line_in, // 1 data
   input wire logic rd_stb_in, // read strobe
   input wire logic wr_stb_in, // write strobe
   input wire logic [7:0] wdata_in, // write byte
   input wire logic [7:0] rdata_in, // read byte
   input wire logic dma_req_in, // dma request
   input wire logic dma_ack_in, // dma acknowledge
   input wire logic irq_in // interrupt
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   wire data_wr = wr_stb_in && register_select_line_in && !dma_ack_in;
   wire data_rd = rd_stb_in && register_select_line_in && !dma_ack_in;
   // a status read may run straight into a data read; byte moves may not
   wire move_rd = rd_stb_in && (register_select_line_in || dma_ack_in);
   AST_ACK_STB: assert property (
      dma_ack_in |-> rd_stb_in ^ wr_stb_in)
      else $error("ack without one strobe");
   AST_ACK_REQ: assert property (dma_ack_in |-> dma_req_in)
      else $error("ack without request");
   AST_REQ_DROP: assert property (dma_ack_in |=> !dma_req_in)
      else $error("request kept after ack");
   AST_WR_GATE: assert property (
      data_wr |-> $past(rdata_in[7:6]) == 2'b10)
      else $error("write without request and direction");
   AST_RD_GATE: assert property (
      data_rd |-> $past(rdata_in[7:6]) == 2'b11)
      else $error("read without request and direction");
   AST_IRQ_CLR: assert property (
      data_rd && irq_in && $past(rdata_in[7:5]) == 3'b110 |->
      ##[1:2] !irq_in)
      else $error("interrupt not cleared by result read");
   AST_RD_PULSE: assert property (move_rd |=> !rd_stb_in)
      else $error("read strobe too long");
   AST_WR_PULSE: assert property (wr_stb_in |=> !wr_stb_in)
      else $error("write strobe too long");
   AST_STB_EXCL: assert property (!(rd_stb_in && wr_stb_in))
      else $error("both strobes");
   AST_WD_HOLD: assert property (wr_stb_in |=> $stable(wdata_in))
      else $error("write byte changed after strobe");
endmodule : dch_port_monitor
`default_nettype wire

// File: bench/disk_ctrl_host_port_tb.sv
// Purpose: both ends joined; commands run in interrupt and dma modes
// Assumes: apb answers come in the first access cycle or later
// Notes: disk bytes are random after a first 00, one offered per transfer
`timescale 1ns/1ps
`default_nettype none
module disk_ctrl_host_port_tb;
   import dch_pkg::*;
   logic clk = 0, rst = 1, pin = 1, fm = 0, dma = 0, ld = 0, xr;
   logic psel = 0, pen = 0, pw = 0, pr, pe, ovr;
   logic [7:0] pa = 8'h00, xd = 8'h00, res;
   logic [31:0] pd = 32'h0, prd, r;
   logic [3:0] ridx;
   dch_rate_e sw = DCH_R1000, br;
   dch_prof_s prof;
   logic [7:0] q[$];
   int failures = 0, checks_done = 0;
   // disk bytes offered and taken; one driver each
   int xn = 0, xt = 0;
   wire xv = (xn != xt);
   logic e;
   dch_if bus_if ();
   assign prof = '{4'h2, 4'h2, 16'h0002, 1'b1, 1'b0, 1'b0, 2'h0};
   assign res = {4'hA, ridx};
   dch_host dch_host_i (.core_clk_in(clk), .rst_in(rst), .bus(bus_if.host),
      .psel_in(psel), .penable_in(pen), .pwrite_in(pw), .paddr_in(pa),
      .pwdata_in(pd), .prdata_out(prd), .pready_out(pr), .pslverr_out(pe));
   dch_device dch_device_i (.core_clk_in(clk), .rst_in(rst),
      .bus(bus_if.dev), .rate_pin_in(pin), .fm_in(fm), .dma_mode_in(dma),
      .sw_rate_load_in(ld), .sw_rate_in(sw), .prof_in(prof),
      .res_byte_in(res), .xdat_valid_in(xv), .xdat_in(xd),
      .xdat_ready_out(xr), .xdat_valid_out(), .xdat_out(), .cmd_stb_out(),
      .cmd_first_out(), .cmd_byte_out(), .res_idx_out(ridx),
      .overrun_out(ovr), .bit_rate_out(br));
   dch_port_monitor dch_port_monitor_i (.core_clk_in(clk), .rst_in(rst),
      .register_select_line_in(bus_if.register_select_line),
      .rd_stb_in(bus_if.rd_stb), .wr_stb_in(bus_if.wr_stb),
      .wdata_in(bus_if.wdata), .rdata_in(bus_if.rdata),
      .dma_req_in(bus_if.dma_req), .dma_ack_in(bus_if.dma_ack),
      .irq_in(bus_if.irq));
   initial begin
      forever #10 clk = ~clk;
   end
   task check(input string n, input logic [31:0] s, input logic [31:0] x);
      checks_done++;
      if (s !== x) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, x, s);
      end
   endtask : check
   task results;
      if (failures == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1;
      pen <= 0;
      pw <= w;
      pa <= a;
      pd <= d;
      @(posedge clk);
      pen <= 1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pr !== 1'b1 && n < 100);
      if (n >= 100) begin
         failures++;
         results();
      end
      r = prd;
      e = pe;
      psel <= 0;
      pen <= 0;
   endtask : apb
   // poll host status bit until it reads v; bounded
   task poll(input int b, input logic v);
      int n;
      n = 0;
      do begin
         apb(0, `DCH_H_STAT, 32'h0);
         n++;
      end while (r[b] !== v && n < 400);
      if (n >= 400) begin
         failures++;
         results();
      end
   endtask : poll
   task rate(input logic p, input logic f, input dch_rate_e x);
      pin <= p;
      fm <= f;
      repeat (8) @(posedge clk);
      check("rate", 32'(br), 32'(x));
   endtask : rate
   // each disk byte taken becomes the next expected host byte
   always @(posedge clk) begin
      if (xv && xr) begin
         q.push_back(xd);
         xt <= xt + 1;
         xd <= 8'($urandom);
      end
   end
   always @(posedge clk) begin
      if (psel && pen && pr && !pw && pa == `DCH_H_RXDATA)
         check("rx byte", 32'(prd[7:0]), 32'(q.pop_front()));
   end
   initial begin
      void'($urandom(13));
      repeat (4) @(posedge clk);
      rst <= 0;
      rate(1, 0, DCH_R500);
      rate(0, 0, DCH_R250);
      rate(0, 1, DCH_R125);
      ld <= 1;
      @(posedge clk);
      ld <= 0;
      rate(1, 0, DCH_R1000);
      apb(0, 8'h20, 32'h0);
      check("unmapped err", 32'(e), 32'h1);
      for (int m = 0; m < 2; m++) begin
         dma <= m[0];
         apb(1, `DCH_H_DMA, m ? 32'h3 : 32'h0);
         for (int c = 0; c < 2; c++) begin
            poll(0, 0);
            apb(1, `DCH_H_TX, 32'(8'h46 + c));
         end
         for (int i = 0; i < 4; i++) begin
            poll(0, 0);
            if (i < 2) xn <= xn + 1;
            else q.push_back({4'hA, 4'(i - 2)});
            if (m == 0 || i >= 2) apb(1, `DCH_H_RXGO, 32'h0);
            poll(1, 1);
            apb(0, `DCH_H_RXDATA, 32'h0);
         end
      end
      check("overrun", 32'(ovr), 32'h0);
      results();
   end
endmodule : disk_ctrl_host_port_tb
`default_nettype wire

// File: src/dch_device.sv
// Purpose: controller end of the disk host port (status, data, DMA, irq)
// Assumes: command decoder supplies the command profile, disk engine
//    supplies read bytes and takes write bytes
// Notes: profile is sampled the cycle after the first command byte
`timescale 1ns/1ps
`default_nettype none
module dch_device import dch_pkg::*; (
   input wire logic core_clk_in, // core clock, 50 MHz
   input wire logic rst_in, // sync reset, high
   dch_if.dev bus, // processor-side byte bus
   input wire logic rate_pin_in, // async rate pin
   input wire logic fm_in, // FM encoding in use
   input wire logic dma_mode_in, // 1: execution bytes move by DMA
   input wire logic sw_rate_load_in, // pulse: mode command sets rate
   input wire dch_rate_e sw_rate_in, // rate from the mode command
   input wire dch_prof_s prof_in, // profile of command in cmd_byte_out
   input wire logic [7:0] res_byte_in, // result byte at res_idx_out
   input wire logic xdat_valid_in, // disk byte offered (read commands)
   input wire logic [7:0] xdat_in, // disk byte
   output logic xdat_ready_out, // disk byte will be taken
   output logic xdat_valid_out, // pulse: byte for the disk
   output logic [7:0] xdat_out, // byte for the disk
   output logic cmd_stb_out, // pulse: command byte written
   output logic cmd_first_out, // that byte was the first
   output logic [7:0] cmd_byte_out, // last command byte written
   output logic [3:0] res_idx_out, // index of result byte to read
   output logic overrun_out, // overrun seen in this command
   output dch_rate_e bit_rate_out // effective data rate
);
   dch_phase_e state_q, state_d;
   dch_prof_s prof_q;
   logic rqm_q, rqm_d;
   logic irq_q, irq_d;
   logic dreq_q, dreq_d;
   logic pend_q, pend_d;
   logic ack_q;
   logic [3:0] cmd_cnt_q;
   logic [15:0] exec_left_q;
   logic [3:0] seek_q, seek_d;
   logic [11:0] svc_q;
   logic [7:0] hold_q;
   logic [7:0] rdata_q;
   logic [7:0] status_w;
   logic byte_tick_w;
   dch_rate_gen dch_rate_gen_i (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .rate_pin_in(rate_pin_in),
      .fm_in(fm_in),
      .sw_load_in(sw_rate_load_in),
      .sw_rate_in(sw_rate_in),
      .bit_tick_out(),
      .byte_tick_out(byte_tick_w),
      .bit_rate_out(bit_rate_out)
   );
   // profile is valid from the input only in the cycle after first byte
   wire dch_prof_s prof_w = cmd_first_out ? prof_in : prof_q;
   wire data_sel_w = (bus.register_select_line == `DCH_SEL_DATA) &&
      !bus.dma_ack;
   wire data_wr_w = bus.wr_stb && data_sel_w;
   wire data_rd_w = bus.rd_stb && data_sel_w;
   wire in_exec_w = (state_q == DCH_EXEC);
   wire ack_rise_w = bus.dma_ack && !ack_q;
   wire dma_xfer_w = in_exec_w && dma_mode_in && bus.dma_ack &&
      (prof_q.exec_rd ? bus.rd_stb : bus.wr_stb);
   wire pio_xfer_w = in_exec_w && !dma_mode_in &&
      (prof_q.exec_rd ? data_rd_w : data_wr_w);
   wire exec_xfer_w = pend_q && (dma_xfer_w || pio_xfer_w);
   wire new_cmd_w = data_wr_w &&
      (state_q == DCH_IDLE || state_q == DCH_RES);
   wire cmd_done_w = (state_q == DCH_CMD) && cmd_stb_out &&
      (cmd_cnt_q >= prof_w.cmd_len);
   wire first_res_w = (state_q == DCH_RES) && data_rd_w &&
      (res_idx_out == 4'h0);
   // read commands take a byte from the disk side, write commands ask
   // one per byte time
   wire pend_set_w = in_exec_w && !pend_q &&
      (prof_q.exec_rd ? xdat_valid_in : byte_tick_w);
   wire expire_w = pend_q && (svc_q == 12'h001) && !exec_xfer_w;
   wire ovr_byte_w = (res_idx_out == `DCH_RSB1_IDX) && overrun_out;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         DCH_IDLE: begin
            if (data_wr_w) begin
               state_d = DCH_CMD;
            end
         end
         DCH_CMD: begin
            if (cmd_done_w) begin
               if (prof_w.exec_len != 16'h0000) begin
                  state_d = DCH_EXEC;
               end else if (prof_w.res_len != 4'h0) begin
                  state_d = DCH_RES;
               end else begin
                  state_d = DCH_IDLE;
               end
            end
         end
         DCH_EXEC: begin
            if (exec_xfer_w && exec_left_q == 16'h0001) begin
               state_d = (prof_q.res_len != 4'h0) ? DCH_RES : DCH_IDLE;
            end
         end
         DCH_RES: begin
            if (data_wr_w) begin
               state_d = DCH_CMD;
            end else if (data_rd_w &&
                  res_idx_out == prof_q.res_len - 4'h1) begin
               state_d = DCH_IDLE;
            end
         end
      endcase
   end

   always_comb begin
      pend_d = (state_d == DCH_EXEC) &&
         (pend_set_w || (pend_q && !exec_xfer_w));
      // any data port byte drops the request for one cycle at least
      if (data_wr_w || data_rd_w || dma_xfer_w) begin
         rqm_d = 1'b0;
      end else if (state_d == DCH_EXEC) begin
         rqm_d = pend_d && !dma_mode_in;
      end else begin
         rqm_d = 1'b1;
      end
      if (in_exec_w && state_d == DCH_RES) begin
         irq_d = 1'b1;
      end else if (state_d == DCH_EXEC) begin
         irq_d = pend_d && !dma_mode_in;
      end else if (first_res_w) begin
         irq_d = 1'b0;
      end else begin
         irq_d = (state_d == DCH_RES) && irq_q;
      end
      dreq_d = (state_d == DCH_EXEC) && dma_mode_in && pend_d &&
         !ack_rise_w && (dreq_q || !pend_q);
      seek_d = (first_res_w && prof_q.sense) ? 4'h0 : seek_q;
      if (cmd_done_w && prof_w.seek) begin
         seek_d[prof_w.drive] = 1'b1;
      end
   end

   always_comb begin
      status_w = {4'h0, seek_q};
      status_w[`DCH_MSR_RQM] = rqm_q;
      status_w[`DCH_MSR_DIO] = (state_q == DCH_RES) ||
         (in_exec_w && prof_q.exec_rd);
      status_w[`DCH_MSR_NDMA] = in_exec_w && !dma_mode_in;
      status_w[`DCH_MSR_BUSY] = (state_q != DCH_IDLE);
   end

   wire [7:0] res_w = res_byte_in |
      (ovr_byte_w ? 8'(1 << `DCH_RSB1_OVR) : 8'h00);
   wire [7:0] data_w = (state_q == DCH_RES) ? res_w : hold_q;
   wire dsel_w = (bus.register_select_line == `DCH_SEL_DATA) ||
      bus.dma_ack;
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         state_q <= DCH_IDLE;
         prof_q <= '0;
         rqm_q <= 1'b1;
         irq_q <= 1'b0;
         dreq_q <= 1'b0;
         pend_q <= 1'b0;
         ack_q <= 1'b0;
         seek_q <= 4'h0;
         rdata_q <= 8'h00;
      end else begin
         state_q <= state_d;
         if (cmd_first_out) begin
            prof_q <= prof_in;
         end
         rqm_q <= rqm_d;
         irq_q <= irq_d;
         dreq_q <= dreq_d;
         pend_q <= pend_d;
         ack_q <= bus.dma_ack;
         seek_q <= seek_d;
         rdata_q <= dsel_w ? data_w : status_w;
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         cmd_cnt_q <= 4'h0;
         cmd_stb_out <= 1'b0;
         cmd_first_out <= 1'b0;
         cmd_byte_out <= 8'h00;
         res_idx_out <= 4'h0;
         overrun_out <= 1'b0;
      end else begin
         cmd_stb_out <= data_wr_w && state_q != DCH_EXEC;
         cmd_first_out <= new_cmd_w;
         if (data_wr_w && state_q != DCH_EXEC) begin
            cmd_byte_out <= bus.wdata;
            cmd_cnt_q <= new_cmd_w ? 4'h1 : cmd_cnt_q + 4'h1;
         end
         if (state_q != DCH_RES) begin
            res_idx_out <= 4'h0;
         end else if (data_rd_w) begin
            res_idx_out <= res_idx_out + 4'h1;
         end
         if (expire_w) begin
            overrun_out <= 1'b1;
         end else if (new_cmd_w) begin
            overrun_out <= 1'b0;
         end
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         exec_left_q <= 16'h0000;
         svc_q <= 12'h000;
         hold_q <= 8'h00;
         xdat_ready_out <= 1'b0;
         xdat_valid_out <= 1'b0;
         xdat_out <= 8'h00;
      end else begin
         if (cmd_done_w) begin
            exec_left_q <= prof_w.exec_len;
         end else if (exec_xfer_w) begin
            exec_left_q <= exec_left_q - 16'h0001;
         end
         // deadline restarts with every byte that becomes pending
         if (pend_set_w) begin
            svc_q <= dch_svc_cycles(bit_rate_out);
         end else if (pend_q && svc_q != 12'h000) begin
            svc_q <= svc_q - 12'h001;
         end
         if (pend_set_w && prof_q.exec_rd) begin
            hold_q <= xdat_in;
         end
         xdat_ready_out <= (state_d == DCH_EXEC) && prof_w.exec_rd &&
            !pend_d;
         xdat_valid_out <= exec_xfer_w && !prof_q.exec_rd;
         if (exec_xfer_w && !prof_q.exec_rd) begin
            xdat_out <= bus.wdata;
         end
      end
   end
   assign bus.rdata = rdata_q;
   assign bus.dma_req = dreq_q;
   assign bus.irq = irq_q;
endmodule : dch_device
`default_nettype wire

// File: src/dch_host.sv
// Purpose: processor end: APB bridge that runs the status handshake
// Assumes: same clock as the controller, zero-wait APB answers
// Notes: one byte operation at a time; DMA service is automatic
`timescale 1ns/1ps
`default_nettype none
module dch_host import dch_pkg::*; (
   input wire logic core_clk_in, // core clock
   input wire logic rst_in, // sync reset, high
   dch_if.host bus, // controller byte bus
   input wire logic psel_in, // APB select
   input wire logic penable_in, // APB enable
   input wire logic pwrite_in, // APB write
   input wire logic [7:0] paddr_in, // APB byte address
   input wire logic [31:0] pwdata_in, // APB write data
   output logic [31:0] prdata_out, // APB read data
   output logic pready_out, // APB ready
   output logic pslverr_out // APB error
);
   dch_host_e st_q;
   logic op_rd_q, rx_new_q, dma_en_q, dma_rd_q;
   logic [7:0] tx_q, rx_q, msr_q, dma_wb_q;
   logic sel_q, rd_q, wr_q, ack_q;
   logic [7:0] wd_q;

   wire setup_w = psel_in && !penable_in;
   wire acc_w = psel_in && penable_in && pready_out;
   wire busy_w = (st_q != DCH_H_IDLE);
   wire hit_w = (paddr_in == `DCH_H_TX) || (paddr_in == `DCH_H_RXGO) ||
      (paddr_in == `DCH_H_RXDATA) || (paddr_in == `DCH_H_STAT) ||
      (paddr_in == `DCH_H_DMA);
   wire go_addr_w = pwrite_in &&
      (paddr_in == `DCH_H_TX || paddr_in == `DCH_H_RXGO);
   wire go_w = acc_w && go_addr_w && !busy_w;
   wire err_w = !hit_w || (go_addr_w && busy_w);
   wire rqm_w = bus.rdata[`DCH_MSR_RQM];
   wire dio_w = bus.rdata[`DCH_MSR_DIO];
   wire got_w = (st_q == DCH_H_GET && op_rd_q) ||
      (st_q == DCH_H_DWAIT && dma_rd_q);
   wire rx_clr_w = acc_w && !pwrite_in && paddr_in == `DCH_H_RXDATA;
   wire [31:0] stat_w = {16'h0000, msr_q, 4'h0, bus.dma_req, bus.irq,
      rx_new_q, busy_w};
   wire [31:0] rd_w = (paddr_in == `DCH_H_RXDATA) ? {24'h000000, rx_q} :
      (paddr_in == `DCH_H_STAT) ? stat_w :
      (paddr_in == `DCH_H_DMA) ? {16'h0000, dma_wb_q, 6'h00, dma_rd_q,
      dma_en_q} : 32'h00000000;

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         prdata_out <= 32'h00000000;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
         tx_q <= 8'h00;
         op_rd_q <= 1'b0;
         dma_en_q <= 1'b0;
         dma_rd_q <= 1'b0;
         dma_wb_q <= 8'h00;
         rx_new_q <= 1'b0;
      end else begin
         pready_out <= setup_w;
         pslverr_out <= setup_w && err_w;
         prdata_out <= setup_w ? rd_w : 32'h00000000;
         if (go_w) begin
            tx_q <= pwdata_in[7:0];
            op_rd_q <= (paddr_in == `DCH_H_RXGO);
         end
         if (acc_w && pwrite_in && paddr_in == `DCH_H_DMA) begin
            dma_en_q <= pwdata_in[0];
            dma_rd_q <= pwdata_in[1];
            dma_wb_q <= pwdata_in[15:8];
         end
         // a byte arriving as software reads it still counts as new
         rx_new_q <= got_w || (rx_new_q && !rx_clr_w);
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         st_q <= DCH_H_IDLE;
         sel_q <= `DCH_SEL_STATUS;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         ack_q <= 1'b0;
         wd_q <= 8'h00;
         rx_q <= 8'h00;
         msr_q <= 8'h00;
      end else begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         ack_q <= 1'b0;
         if (got_w) begin
            rx_q <= bus.rdata;
         end
         unique case (st_q)
            DCH_H_IDLE: begin
               if (go_w) begin
                  // rdata lags select by a cycle, so select status now
                  sel_q <= `DCH_SEL_STATUS;
                  st_q <= DCH_H_POLL;
               end else if (dma_en_q && bus.dma_req) begin
                  ack_q <= 1'b1;
                  rd_q <= dma_rd_q;
                  wr_q <= !dma_rd_q;
                  wd_q <= dma_wb_q;
                  st_q <= DCH_H_DMA;
               end
            end
            DCH_H_POLL: begin
               sel_q <= `DCH_SEL_STATUS;
               rd_q <= 1'b1;
               st_q <= DCH_H_SAMP;
            end
            DCH_H_SAMP: begin
               msr_q <= bus.rdata;
               if (rqm_w && dio_w == op_rd_q) begin
                  sel_q <= `DCH_SEL_DATA;
                  rd_q <= op_rd_q;
                  wr_q <= !op_rd_q;
                  wd_q <= tx_q;
                  st_q <= DCH_H_XFER;
               end else begin
                  st_q <= DCH_H_POLL;
               end
            end
            DCH_H_XFER: st_q <= DCH_H_GET;
            DCH_H_GET: st_q <= DCH_H_IDLE;
            // the request is still seen high here, so wait it out
            DCH_H_DMA: st_q <= DCH_H_DWAIT;
            DCH_H_DWAIT: st_q <= DCH_H_IDLE;
            default: st_q <= DCH_H_IDLE;
         endcase
      end
   end

   assign bus.register_select_line = sel_q;
   assign bus.rd_stb = rd_q;
   assign bus.wr_stb = wr_q;
   assign bus.wdata = wd_q;
   assign bus.dma_ack = ack_q;
endmodule : dch_host
`default_nettype wire

// File: src/dch_if.sv
// Purpose: byte bus between processor side and disk controller
// Assumes: both ends on core_clk_in, strobes one cycle wide
// Notes: read data answers one cycle after select is set
`timescale 1ns/1ps
`default_nettype none
interface dch_if;
   logic register_select_line;
   logic rd_stb;
   logic wr_stb;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic dma_req;
   logic dma_ack;
   logic irq;
   modport dev (input register_select_line, rd_stb, wr_stb, wdata, dma_ack,
      output rdata, dma_req, irq);
   modport host (output register_select_line, rd_stb, wr_stb, wdata,
      dma_ack, input rdata, dma_req, irq);
endinterface : dch_if
`default_nettype wire

// File: src/dch_pkg.sv
// Purpose: types and shared functions of the disk host port
// Assumes: dch_regs.svh holds all figures
// Notes: cycle counts round down, they are longest times
package dch_pkg;
`include "dch_regs.svh"
   typedef enum logic [1:0] {DCH_IDLE = 2'b00, DCH_CMD = 2'b01,
      DCH_EXEC = 2'b10, DCH_RES = 2'b11} dch_phase_e;
   typedef enum logic [1:0] {DCH_R125 = 2'b00, DCH_R250 = 2'b01,
      DCH_R500 = 2'b10, DCH_R1000 = 2'b11} dch_rate_e;
   typedef enum logic [2:0] {DCH_H_IDLE = 3'b000, DCH_H_POLL = 3'b001,
      DCH_H_SAMP = 3'b010, DCH_H_XFER = 3'b011, DCH_H_GET = 3'b100,
      DCH_H_DMA = 3'b101, DCH_H_DWAIT = 3'b110} dch_host_e;
   // what the command decoder reports about the command under way
   typedef struct packed {
      logic [3:0] cmd_len;
      logic [3:0] res_len;
      logic [15:0] exec_len;
      logic exec_rd;
      logic seek;
      logic sense;
      logic [1:0] drive;
   } dch_prof_s;

   function automatic logic [11:0] dch_svc_cycles(input dch_rate_e r);
      unique case (r)
         DCH_R125: return 12'(`DCH_SVC_NS_125 / `DCH_CLK_NS);
         DCH_R250: return 12'(`DCH_SVC_NS_250 / `DCH_CLK_NS);
         DCH_R500: return 12'(`DCH_SVC_NS_500 / `DCH_CLK_NS);
         DCH_R1000: return 12'(`DCH_SVC_NS_1000 / `DCH_CLK_NS);
      endcase
   endfunction : dch_svc_cycles

   function automatic logic [8:0] dch_bit_cycles(input dch_rate_e r);
      unique case (r)
         DCH_R125: return 9'(`DCH_BIT_NS_125 / `DCH_CLK_NS);
         DCH_R250: return 9'(`DCH_BIT_NS_250 / `DCH_CLK_NS);
         DCH_R500: return 9'(`DCH_BIT_NS_500 / `DCH_CLK_NS);
         DCH_R1000: return 9'(`DCH_BIT_NS_1000 / `DCH_CLK_NS);
      endcase
   endfunction : dch_bit_cycles
endpackage : dch_pkg

// File: src/dch_rate_gen.sv
// Purpose: bit rate choice and bit/byte timing ticks
// Assumes: rate pin is asynchronous
// Notes: software rate, once loaded, overrides the pin until reset
`timescale 1ns/1ps
`default_nettype none
module dch_rate_gen import dch_pkg::*; (
   input wire logic core_clk_in, // core clock
   input wire logic rst_in, // sync reset, high
   input wire logic rate_pin_in, // pin: high 500k, low 250k
   input wire logic fm_in, // FM encoding halves the rate, but not below 125k
   input wire logic sw_load_in, // pulse: load software rate
   input wire dch_rate_e sw_rate_in, // software rate code
   output logic bit_tick_out, // pulse per bit time
   output logic byte_tick_out, // pulse per 8 bit times
   output dch_rate_e bit_rate_out // effective rate
);
   logic [2:0] pin_sync_q;
   logic pin_lvl_q;
   logic sw_set_q;
   dch_rate_e sw_rate_q;
   logic [8:0] div_q;
   logic [2:0] bitn_q;
   wire dch_rate_e mfm_w = sw_set_q ? sw_rate_q :
      (pin_lvl_q ? DCH_R500 : DCH_R250);
   // FM runs one code below; a 125k software code cannot halve further
   wire dch_rate_e eff_w = (fm_in && mfm_w != DCH_R125) ?
      dch_rate_e'(mfm_w - 2'h1) : mfm_w;
   wire tick_w = (div_q == 9'h000);

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         pin_sync_q <= 3'h0;
         pin_lvl_q <= 1'b0;
         sw_set_q <= 1'b0;
         sw_rate_q <= DCH_R250;
         div_q <= 9'h000;
         bitn_q <= 3'h0;
         bit_tick_out <= 1'b0;
         byte_tick_out <= 1'b0;
         bit_rate_out <= DCH_R250;
      end else begin
         pin_sync_q <= {pin_sync_q[1:0], rate_pin_in};
         if (pin_sync_q[1] == pin_sync_q[2]) begin
            pin_lvl_q <= pin_sync_q[2];
         end
         if (sw_load_in) begin
            sw_set_q <= 1'b1;
            sw_rate_q <= sw_rate_in;
         end
         div_q <= tick_w ? dch_bit_cycles(eff_w) - 9'h001 : div_q - 9'h001;
         if (tick_w) begin
            bitn_q <= bitn_q + 3'h1;
         end
         bit_tick_out <= tick_w;
         byte_tick_out <= tick_w && (bitn_q == 3'h7);
         bit_rate_out <= eff_w;
      end
   end
endmodule : dch_rate_gen
`default_nettype wire

// File: src/dch_regs.svh
// Purpose: offsets, bit positions and timing figures of the disk host port
// Assumes: 50 MHz core clock
// Notes: times in ns; cycle counts are derived from them
`ifndef DCH_REGS_SVH
`define DCH_REGS_SVH
`define DCH_CLK_NS 20
// register_select_line values
`define DCH_SEL_STATUS 1'h0
`define DCH_SEL_DATA 1'h1
// main_status bit positions
`define DCH_MSR_RQM 7
`define DCH_MSR_DIO 6
`define DCH_MSR_NDMA 5
`define DCH_MSR_BUSY 4
// overrun flag in result_status_byte_one, the result byte at index 1
`define DCH_RSB1_IDX 4'h1
`define DCH_RSB1_OVR 4
// service deadline per effective rate: 8 bit times less 16 clocks at 8 MHz
`define DCH_SVC_NS_125 62000
`define DCH_SVC_NS_250 30000
`define DCH_SVC_NS_500 14000
`define DCH_SVC_NS_1000 6000
// bit time per effective rate
`define DCH_BIT_NS_125 8000
`define DCH_BIT_NS_250 4000
`define DCH_BIT_NS_500 2000
`define DCH_BIT_NS_1000 1000
// host bridge APB word offsets
`define DCH_H_TX 8'h00
`define DCH_H_RXGO 8'h04
`define DCH_H_RXDATA 8'h08
`define DCH_H_STAT 8'h0C
`define DCH_H_DMA 8'h10
`endif
